// File: pawd_checker.sv
/* checks pci answer timing and select shape.
   assumes: bound into pawd_top, srst active high. */
`timescale 1ns/10ps
`default_nettype none
module pawd_checker (
    input wire logic                    core_clk,
    input wire logic                    srst,
    input wire pawd_pkg::pawd_pci_req_t pci_req,
    input wire pawd_pkg::pawd_pci_rsp_t pci_rsp,
    input wire pawd_pkg::pawd_map_req_t dma_req,
    input wire pawd_pkg::pawd_map_rsp_t dma_rsp
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_req; pci_req.valid; endsequence
    sequence s_ans; pci_rsp.done; endsequence
    property p_done; s_req |=> s_ans; endproperty
    a_done: assert property (p_done) else $error("no pci answer");
    property p_one; s_ans |-> $onehot0(pci_rsp.sel); endproperty
    a_one: assert property (p_one) else $error("two selects");
    property p_miss; s_ans |-> pci_rsp.claim != pci_rsp.miss; endproperty
    a_miss: assert property (p_miss) else $error("claim and miss");
    property p_clm; s_ans |-> pci_rsp.claim == (pci_rsp.sel != '0); endproperty
    a_clm: assert property (p_clm) else $error("claim without select");
    // page offset passes through untouched, remap only touches 31:12
    property p_low; s_req ##1 pci_rsp.claim |->
        pci_rsp.addr[11:0] == $past(pci_req.addr[11:0]); endproperty
    a_low: assert property (p_low) else $error("offset changed");
    property p_io; s_ans ##0 pci_rsp.sel[10] |-> $past(pci_req.io); endproperty
    a_io: assert property (p_io) else $error("io window on memory");
    property p_dac; s_req ##0 pci_req.dac |=> pci_rsp.sel[11:0] == '0; endproperty
    a_dac: assert property (p_dac) else $error("dac hit single");
    property p_dma; dma_req.valid |=> dma_rsp.done; endproperty
    a_dma: assert property (p_dma) else $error("no dma answer");
endmodule
bind pawd_top pawd_checker chk_u (.core_clk, .srst, .pci_req, .pci_rsp,
    .dma_req, .dma_rsp);
`default_nettype wire

// File: pawd_pci_master.sv
/* pci master model, one address phase per go.
   assumes: bench drives go after clock edges. */
`timescale 1ns/10ps
`default_nettype none
module pawd_pci_master (
    input  wire logic                   core_clk,
    input  wire logic                   go,
    input  wire logic [31:0]            a_in,
    input  wire logic [2:0]             f_in,
    output var pawd_pkg::pawd_pci_req_t pci_req
);
    initial pci_req = '0;
    // idle bus toggles the last address: inverted one cycle, stale again the next
    always @(posedge core_clk) begin
        if (go) pci_req <= '{1'b1, f_in[2], f_in[1], {31'h0, f_in[0]}, a_in};
        else pci_req <= '{1'b0, 1'b0, 1'b0, ~pci_req.addr_hi, ~pci_req.addr};
    end
endmodule
`default_nettype wire

// File: pawd_pkg.sv
/*
 * constants, register map, reset maps and carriers of the pci
 * address window decoder.
 * assumes: one 125 mhz core clock, synchronous reset, axi4-lite
 * register access with 12 address bits.
 */
// Summary of operation
// - twelve single windows: sdram 0-3, device 0-3, boot, mem and i/o regs.
// - twelve dual-address windows: sdram 0-3, device 0-3, boot, cpu bus forward.
// - dual-address windows also match plain 32-bit addresses when high base is zero.
// - a window hits when address bits 31 down to N equal its base.
// - N is the lowest zero bit of the size register.
// - comparison starts at bit 12, so windows are at least 4 kbyte.
// - a cpu-side window with low above high never hits.
// - a window whose disable bit is one is never claimed.
// - dma addresses decode through the same cpu-side window map.
// - cpu miss latches address, sets cause bit 0, interrupts unless masked.
// - a pci miss gets no claim, only a done response with miss set.
// - dma miss latches address and channel, sets cause, interrupts unless masked.
// - sdram windows reset to consecutive 8 mbyte ranges from zero.
// - device and boot windows reset to their fixed default ranges.
// - cpu internal window is 1 mbyte at one of two bases by strap.
// - cpu-side pci windows reset to 32 mbyte at fixed bases.
// - pci internal windows reset at 0x1400_0000, 64 kbyte mem, 4 kbyte i/o.
// - dual-address bank windows reset like their 32-bit counterparts.
// - on a hit, unmasked bits 31 to 12 are replaced by the remap bits.
package pawd_pkg;

    localparam int NUM_SAC = 12;
    localparam int NUM_DAC = 12;
    localparam int NUM_WIN = 24;
    localparam int NUM_CPU = 17;
    localparam int WIN_INT_IO  = 10;
    localparam int CPU_WIN_INT = 14;

    // ------------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [11:0] OFS_WIN          = 12'h000;
    localparam logic [11:0] OFS_WIN_DIS      = 12'h180;
    localparam logic [11:0] OFS_DEC_CTRL     = 12'h184;
    localparam logic [11:0] OFS_CPU_WIN      = 12'h200;
    localparam logic [11:0] OFS_CPU_ERR_ADDR = 12'h300;
    localparam logic [11:0] OFS_CPU_CAUSE    = 12'h304;
    localparam logic [11:0] OFS_DMA_ERR_ADDR = 12'h308;
    localparam logic [11:0] OFS_DMA_ERR_CHAN = 12'h30c;
    localparam logic [11:0] OFS_DMA_CAUSE    = 12'h310;
    localparam logic [11:0] OFS_ERR_MASK     = 12'h314;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // ------------------------------------------------------------------
    // reset maps, bits 31:12 of base and size, index 0 rightmost
    // ------------------------------------------------------------------
    localparam logic [NUM_WIN-1:0][19:0] BASE_RST = {
        20'h0_0000, 20'h0_0000, 20'h0_0000, 20'hf_f800,
        20'hf_f000, 20'h1_d000, 20'h1_c800, 20'h1_c000,
        20'h0_1800, 20'h0_1000, 20'h0_0800, 20'h0_0000,
        20'h0_0000, 20'h1_4000, 20'h1_4000, 20'hf_f800,
        20'hf_f000, 20'h1_d000, 20'h1_c800, 20'h1_c000,
        20'h0_1800, 20'h0_1000, 20'h0_0800, 20'h0_0000};
    localparam logic [NUM_WIN-1:0][19:0] SIZE_RST = {
        20'h0_0000, 20'h0_0000, 20'h0_0000, 20'h0_07ff,
        20'h0_07ff, 20'h0_0fff, 20'h0_07ff, 20'h0_07ff,
        20'h0_07ff, 20'h0_07ff, 20'h0_07ff, 20'h0_07ff,
        20'h0_0000, 20'h0_0000, 20'h0_000f, 20'h0_07ff,
        20'h0_07ff, 20'h0_0fff, 20'h0_07ff, 20'h0_07ff,
        20'h0_07ff, 20'h0_07ff, 20'h0_07ff, 20'h0_07ff};
    // spare slots and the cpu forward window come up disabled
    localparam logic [NUM_WIN-1:0] WIN_DIS_RST = 24'he0_0800;
    localparam logic [NUM_CPU-1:0][11:0] CPU_LO_RST = {
        12'hfff, 12'hfff, 12'h140, 12'hf60, 12'hf40, 12'hf20,
        12'h120, 12'h100, 12'hff8, 12'hff0, 12'h1d0, 12'h1c8,
        12'h1c0, 12'h018, 12'h010, 12'h008, 12'h000};
    localparam logic [NUM_CPU-1:0][11:0] CPU_HI_RST = {
        12'h000, 12'h000, 12'h140, 12'hf7f, 12'hf5f, 12'hf3f,
        12'h13f, 12'h11f, 12'hfff, 12'hff7, 12'h1df, 12'h1cf,
        12'h1c7, 12'h01f, 12'h017, 12'h00f, 12'h007};
    localparam logic [11:0] CPU_INT_ALT  = 12'hf10;
    localparam logic [1:0]  INIT_CNT_RST = 2'h3;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic        dac;
        logic        io;
        logic [31:0] addr_hi;
        logic [31:0] addr;
    } pawd_pci_req_t;

    typedef struct packed {
        logic               done;
        logic               claim;
        logic               miss;
        logic [NUM_WIN-1:0] sel;
        logic [31:0]        addr;
    } pawd_pci_rsp_t;

    typedef struct packed {
        logic        valid;
        logic [1:0]  chan;
        logic [31:0] addr;
    } pawd_map_req_t;

    typedef struct packed {
        logic       done;
        logic       hit;
        logic [4:0] tgt;
    } pawd_map_rsp_t;

endpackage

// File: pawd_top.sv
/*
 * pci window decoder with cpu-side map lookup for cpu and
 * dma accesses, error capture and axi4-lite registers.
 * assumes: requests come from logic on core_clk; the strap is a pin.
 */
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module pawd_top (
    input  wire logic                    core_clk,
    input  wire logic                    srst,
    input  wire logic                    int_base_strap,
    input  wire logic [11:0]             s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    input  wire logic [11:0]             s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    input  wire pawd_pkg::pawd_pci_req_t pci_req,
    output pawd_pkg::pawd_pci_rsp_t      pci_rsp,
    input  wire pawd_pkg::pawd_map_req_t cpu_req,
    output pawd_pkg::pawd_map_rsp_t      cpu_rsp,
    input  wire pawd_pkg::pawd_map_req_t dma_req,
    output pawd_pkg::pawd_map_rsp_t      dma_rsp,
    output logic                         cpu_err_int,
    output logic                         dma_err_int
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [pawd_pkg::NUM_WIN-1:0][19:0] base;
        logic [pawd_pkg::NUM_WIN-1:0][19:0] size;
        logic [pawd_pkg::NUM_WIN-1:0][19:0] remap;
        logic [pawd_pkg::NUM_DAC-1:0][31:0] base_hi;
        logic [pawd_pkg::NUM_WIN-1:0]       win_dis;
        logic                               remap_wr_dis;
        logic [pawd_pkg::NUM_CPU-1:0][11:0] cpu_lo;
        logic [pawd_pkg::NUM_CPU-1:0][11:0] cpu_hi;
        logic [31:0]                        cpu_err_addr;
        logic [31:0]                        dma_err_addr;
        logic [1:0]                         dma_err_chan;
        logic                               cpu_cause;
        logic                               dma_cause;
        logic [1:0]                         err_mask;
        logic                               cpu_irq;
        logic                               dma_irq;
        logic                               strap_s1;
        logic                               strap_s2;
        logic [1:0]                         init_cnt;
        logic                               aw_have;
        logic [11:0]                        aw_addr;
        logic                               w_have;
        logic [31:0]                        wdata;
        logic [3:0]                         wstrb;
        logic                               awready;
        logic                               wready;
        logic                               bvalid;
        logic [1:0]                         bresp;
        logic                               arready;
        logic                               rvalid;
        logic [31:0]                        rdata;
        logic [1:0]                         rresp;
        pawd_pkg::pawd_pci_rsp_t            pci;
        pawd_pkg::pawd_map_rsp_t            cpu;
        pawd_pkg::pawd_map_rsp_t            dma;
    } pawd_state_t;

    pawd_state_t st_ff;
    pawd_state_t nxt_st;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // ones below the lowest zero of a size;
    // higher stray ones still compare
    function automatic logic [19:0] low_ones(input logic [19:0] sz);
        low_ones = sz & ~(sz + 20'h0_0001);
    endfunction

    function automatic pawd_pkg::pawd_map_rsp_t cpu_lookup(
        input pawd_state_t   s,
        input logic [31:0]   addr);
        cpu_lookup = '0;
        cpu_lookup.done = 1'b1;
        // lowest hit is kept
        for (int j = pawd_pkg::NUM_CPU - 1; j >= 0; j--) begin
            if (s.cpu_lo[j] <= s.cpu_hi[j] &&
                addr[31:20] >= s.cpu_lo[j] &&
                addr[31:20] <= s.cpu_hi[j]) begin
                cpu_lookup.hit = 1'b1;
                cpu_lookup.tgt = 5'(j);
            end
        end
    endfunction

    // read value and decode of one word
    function automatic logic [32:0] reg_read(
        input pawd_state_t s,
        input logic [11:0] a);
        int i;
        reg_read = {1'b1, 32'h0000_0000};
        i = int'(a[8:4]);
        if (a < pawd_pkg::OFS_WIN_DIS) begin
            case (a[3:2])
                2'h0: reg_read[31:0] = {s.base[i], 12'h000};
                2'h1: reg_read[31:0] = {s.size[i], 12'hfff};
                2'h2: reg_read[31:0] = {s.remap[i], 12'h000};
                default: begin
                    if (i >= pawd_pkg::NUM_SAC) begin
                        reg_read[31:0] = s.base_hi[i - pawd_pkg::NUM_SAC];
                    end else begin
                        reg_read[32] = 1'b0;
                    end
                end
            endcase
        end else if (a >= pawd_pkg::OFS_CPU_WIN &&
                     int'(a[7:3]) < pawd_pkg::NUM_CPU &&
                     a < pawd_pkg::OFS_CPU_ERR_ADDR) begin
            i = int'(a[7:3]);
            reg_read[31:0] = {20'h0_0000,
                              a[2] ? s.cpu_hi[i] : s.cpu_lo[i]};
        end else begin
            case ({a[11:2], 2'h0})
                pawd_pkg::OFS_WIN_DIS:
                    reg_read[31:0] = {8'h00, s.win_dis};
                pawd_pkg::OFS_DEC_CTRL:
                    reg_read[31:0] = {31'h0000_0000, s.remap_wr_dis};
                pawd_pkg::OFS_CPU_ERR_ADDR:
                    reg_read[31:0] = s.cpu_err_addr;
                pawd_pkg::OFS_CPU_CAUSE:
                    reg_read[31:0] = {31'h0000_0000, s.cpu_cause};
                pawd_pkg::OFS_DMA_ERR_ADDR:
                    reg_read[31:0] = s.dma_err_addr;
                pawd_pkg::OFS_DMA_ERR_CHAN:
                    reg_read[31:0] = {30'h0000_0000, s.dma_err_chan};
                pawd_pkg::OFS_DMA_CAUSE:
                    reg_read[31:0] = {31'h0000_0000, s.dma_cause};
                pawd_pkg::OFS_ERR_MASK:
                    reg_read[31:0] = {30'h0000_0000, s.err_mask};
                default:
                    reg_read[32] = 1'b0;
            endcase
        end
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    always_comb begin
        logic [32:0]        rd;
        logic [31:0]        wv;
        logic [11:0]        wa;
        logic               cpu_clr;
        logic               dma_clr;
        logic [19:0]        ign;
        logic [31:0]        hi;
        logic               hit;
        int                 wi;
        nxt_st  = st_ff;
        rd      = '0;
        wv      = '0;
        wa      = st_ff.aw_addr;
        cpu_clr = 1'b0;
        dma_clr = 1'b0;
        ign     = '0;
        hi      = '0;
        hit     = 1'b0;
        wi      = int'(wa[8:4]);

        // strap is synchronised, then applied once
        nxt_st.strap_s1 = int_base_strap;
        nxt_st.strap_s2 = st_ff.strap_s1;
        if (st_ff.init_cnt != 2'h0) begin
            nxt_st.init_cnt = st_ff.init_cnt - 2'h1;
        end
        if (st_ff.init_cnt == 2'h1 && st_ff.strap_s2) begin
            nxt_st.cpu_lo[pawd_pkg::CPU_WIN_INT] = pawd_pkg::CPU_INT_ALT;
            nxt_st.cpu_hi[pawd_pkg::CPU_WIN_INT] = pawd_pkg::CPU_INT_ALT;
        end

        // --------------------------------------------------------------
        // axi4-lite write channel
        // --------------------------------------------------------------
        if (s_axi_awvalid && st_ff.awready) begin
            nxt_st.aw_have = 1'b1;
            nxt_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st_ff.wready) begin
            nxt_st.w_have = 1'b1;
            nxt_st.wdata  = s_axi_wdata;
            nxt_st.wstrb  = s_axi_wstrb;
        end
        if (st_ff.bvalid && s_axi_bready) begin
            nxt_st.bvalid = 1'b0;
        end
        if (st_ff.aw_have && st_ff.w_have && !st_ff.bvalid) begin
            rd = reg_read(st_ff, wa);
            for (int b = 0; b < 4; b++) begin
                wv[b*8 +: 8] = st_ff.wstrb[b] ? st_ff.wdata[b*8 +: 8]
                                              : rd[b*8 +: 8];
            end
            nxt_st.aw_have = 1'b0;
            nxt_st.w_have  = 1'b0;
            nxt_st.bvalid  = 1'b1;
            nxt_st.bresp   = rd[32] ? pawd_pkg::RESP_OKAY
                                    : pawd_pkg::RESP_SLVERR;
            if (wa < pawd_pkg::OFS_WIN_DIS) begin
                case (wa[3:2])
                    2'h0: begin
                        nxt_st.base[wi] = wv[31:12];
                        // unless remap_wr_dis is set, a new base falls back to a one to one map
                        if (!st_ff.remap_wr_dis) begin
                            nxt_st.remap[wi] = wv[31:12];
                        end
                    end
                    2'h1: nxt_st.size[wi]  = wv[31:12];
                    2'h2: nxt_st.remap[wi] = wv[31:12];
                    default: begin
                        if (wi >= pawd_pkg::NUM_SAC) begin
                            nxt_st.base_hi[wi - pawd_pkg::NUM_SAC] = wv;
                        end
                    end
                endcase
            end else if (rd[32] && wa >= pawd_pkg::OFS_CPU_WIN &&
                         wa < pawd_pkg::OFS_CPU_ERR_ADDR) begin
                if (wa[2]) begin
                    nxt_st.cpu_hi[int'(wa[7:3])] = wv[11:0];
                end else begin
                    nxt_st.cpu_lo[int'(wa[7:3])] = wv[11:0];
                end
            end else begin
                case ({wa[11:2], 2'h0})
                    pawd_pkg::OFS_WIN_DIS:
                        nxt_st.win_dis = wv[pawd_pkg::NUM_WIN-1:0];
                    pawd_pkg::OFS_DEC_CTRL:
                        nxt_st.remap_wr_dis = wv[0];
                    pawd_pkg::OFS_CPU_CAUSE:
                        cpu_clr = st_ff.wstrb[0] && st_ff.wdata[0];
                    pawd_pkg::OFS_DMA_CAUSE:
                        dma_clr = st_ff.wstrb[0] && st_ff.wdata[0];
                    pawd_pkg::OFS_ERR_MASK:
                        nxt_st.err_mask = wv[1:0];
                    default: ;
                endcase
            end
        end
        nxt_st.awready = !nxt_st.aw_have;
        nxt_st.wready  = !nxt_st.w_have;

        // --------------------------------------------------------------
        // axi4-lite read channel
        // --------------------------------------------------------------
        if (st_ff.rvalid && s_axi_rready) begin
            nxt_st.rvalid = 1'b0;
        end
        if (s_axi_arvalid && st_ff.arready) begin
            rd            = reg_read(st_ff, s_axi_araddr);
            nxt_st.rvalid = 1'b1;
            nxt_st.rdata  = rd[31:0];
            nxt_st.rresp  = rd[32] ? pawd_pkg::RESP_OKAY
                                   : pawd_pkg::RESP_SLVERR;
        end
        nxt_st.arready = !nxt_st.rvalid;

        // --------------------------------------------------------------
        // pci window decode, all windows in parallel
        // --------------------------------------------------------------
        nxt_st.pci = '0;
        if (pci_req.valid) begin
            nxt_st.pci.done = 1'b1;
            for (int i = pawd_pkg::NUM_WIN - 1; i >= 0; i--) begin
                ign = low_ones(st_ff.size[i]);
                hi  = i >= pawd_pkg::NUM_SAC ?
                      st_ff.base_hi[i - pawd_pkg::NUM_SAC] : 32'h0000_0000;
                // single address cycles have a zero upper half
                hit = ((pci_req.addr[31:12] ^ st_ff.base[i]) & ~ign)
                      == 20'h0_0000 &&
                      (pci_req.dac ? pci_req.addr_hi : 32'h0000_0000)
                      == hi &&
                      !(pci_req.dac && i < pawd_pkg::NUM_SAC) &&
                      pci_req.io == (i == pawd_pkg::WIN_INT_IO) &&
                      !st_ff.win_dis[i];
                if (hit) begin
                    // lowest index wins on overlap
                    nxt_st.pci.sel   = '0;
                    nxt_st.pci.sel[i] = 1'b1;
                    nxt_st.pci.claim = 1'b1;
                    nxt_st.pci.addr  = {(st_ff.remap[i] & ~ign) |
                                        (pci_req.addr[31:12] & ign),
                                        pci_req.addr[11:0]};
                end
            end
            nxt_st.pci.miss = !nxt_st.pci.claim;
        end

        // --------------------------------------------------------------
        // cpu and dma lookups through the cpu-side map
        // --------------------------------------------------------------
        nxt_st.cpu = '0;
        nxt_st.dma = '0;
        if (cpu_req.valid) begin
            nxt_st.cpu = cpu_lookup(st_ff, cpu_req.addr);
        end
        if (dma_req.valid) begin
            nxt_st.dma = cpu_lookup(st_ff, dma_req.addr);
        end
        // a miss beats a same-cycle clear
        if (cpu_clr) begin
            nxt_st.cpu_cause = 1'b0;
        end
        if (dma_clr) begin
            nxt_st.dma_cause = 1'b0;
        end
        if (cpu_req.valid && !nxt_st.cpu.hit) begin
            nxt_st.cpu_err_addr = cpu_req.addr;
            nxt_st.cpu_cause    = 1'b1;
        end
        if (dma_req.valid && !nxt_st.dma.hit) begin
            nxt_st.dma_err_addr = dma_req.addr;
            nxt_st.dma_err_chan = dma_req.chan;
            nxt_st.dma_cause    = 1'b1;
        end
        nxt_st.cpu_irq = nxt_st.cpu_cause && !nxt_st.err_mask[0];
        nxt_st.dma_irq = nxt_st.dma_cause && !nxt_st.err_mask[1];
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk) begin
        if (srst) begin
            st_ff          <= '0;
            st_ff.base     <= pawd_pkg::BASE_RST;
            st_ff.size     <= pawd_pkg::SIZE_RST;
            st_ff.remap    <= pawd_pkg::BASE_RST;
            st_ff.win_dis  <= pawd_pkg::WIN_DIS_RST;
            st_ff.cpu_lo   <= pawd_pkg::CPU_LO_RST;
            st_ff.cpu_hi   <= pawd_pkg::CPU_HI_RST;
            st_ff.init_cnt <= pawd_pkg::INIT_CNT_RST;
            st_ff.err_mask <= 2'h3;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign s_axi_awready = st_ff.awready;
    assign s_axi_wready  = st_ff.wready;
    assign s_axi_bvalid  = st_ff.bvalid;
    assign s_axi_bresp   = st_ff.bresp;
    assign s_axi_arready = st_ff.arready;
    assign s_axi_rvalid  = st_ff.rvalid;
    assign s_axi_rdata   = st_ff.rdata;
    assign s_axi_rresp   = st_ff.rresp;
    assign pci_rsp       = st_ff.pci;
    assign cpu_rsp       = st_ff.cpu;
    assign dma_rsp       = st_ff.dma;
    assign cpu_err_int   = st_ff.cpu_irq;
    assign dma_err_int   = st_ff.dma_irq;

endmodule
`default_nettype wire

// File: pawd_top_test.sv
/* self-checking bench of the window decoder.
   assumes: design, master and checker compiled. */
`timescale 1ns/10ps
`default_nettype none
module pawd_top_test;
    logic core_clk = 0, srst = 1, int_base_strap = 1, m_go = 0;
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, m_a = '0;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] m_f = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, s_axi_awready, s_axi_wready;
    logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, cpu_err_int, dma_err_int;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    pawd_pkg::pawd_pci_req_t pci_req;
    pawd_pkg::pawd_pci_rsp_t pci_rsp;
    pawd_pkg::pawd_map_req_t cpu_req = '0, dma_req = '0;
    pawd_pkg::pawd_map_rsp_t cpu_rsp, dma_rsp, r;
    int n_mismatch = 0, checks_done = 0;
    logic [31:0] bt [9] = '{32'h0000_0000, 32'h0080_0000, 32'h0100_0000,
        32'h0180_0000, 32'h1c00_0000, 32'h1c80_0000, 32'h1d00_0000,
        32'hff00_0000, 32'hff80_0000};
    pawd_top dut_u (.*);
    pawd_pci_master pm_u (.core_clk, .go(m_go), .a_in(m_a), .f_in(m_f), .pci_req);
    always #4 core_clk = ~core_clk;
    task chk(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_mismatch++;
            $display("wrong value at %0t: %h vs %h", $time, g, e);
        end
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        {s_axi_awaddr, s_axi_wdata} <= {a, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do @(posedge core_clk); while (!(s_axi_awready && s_axi_wready));
        {s_axi_awvalid, s_axi_wvalid} <= 2'h0;
        do @(posedge core_clk); while (!s_axi_bvalid);
        s_axi_bready <= 1'b0;
    endtask
    task rd(input logic [11:0] a, input logic [31:0] e, input logic [1:0] p);
        @(posedge core_clk);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
        do @(posedge core_clk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (!s_axi_rvalid);
        s_axi_rready <= 1'b0;
        chk(s_axi_rdata, e);
        chk(s_axi_rresp, p);
    endtask
    task pq(input logic [31:0] a, input logic [2:0] f, input int w);
        @(posedge core_clk);
        {m_go, m_a, m_f} <= {1'b1, a, f};
        @(posedge core_clk);
        m_go <= 1'b0;
        do @(posedge core_clk); while (!pci_rsp.done);
        chk(pci_rsp.claim, w >= 0);
        chk(pci_rsp.sel, w < 0 ? 32'h0000_0000 : 32'h0000_0001 << w);
    endtask
    task mq(input logic d, input logic [31:0] a, input int t);
        @(posedge core_clk);
        if (d) dma_req <= '{1'b1, 2'h2, a};
        else cpu_req <= '{1'b1, 2'h0, a};
        @(posedge core_clk);
        {dma_req.valid, cpu_req.valid} <= 2'h0;
        @(posedge core_clk);
        r = d ? dma_rsp : cpu_rsp;
        chk(r.hit, t >= 0);
        if (t >= 0) chk(r.tgt, t);
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        give_verdict;
    end
    initial begin
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
        wr(12'h180, 32'h00ff_f800);
        for (int i = 0; i < 9; i++) pq(bt[i] | 32'h007f_fabc, 3'h0, i);
        pq(32'h1400_f000, 3'h0, 9);
        pq(32'h1400_0abc, 3'h2, 10);
        pq(32'h1400_1000, 3'h2, -1);
        $display("sac done");
        wr(12'h180, 32'h00e0_0fff);
        for (int i = 0; i < 9; i++) pq(bt[i], 3'h4, 12 + i);
        pq(32'h0100_0000, 3'h0, 14);
        pq(32'h0000_0000, 3'h5, -1);
        $display("dac done");
        wr(12'h000, 32'h4000_0000);
        wr(12'h004, 32'h0000_0000);
        wr(12'h008, 32'h8000_0000);
        wr(12'h180, 32'h00ff_f800);
        pq(32'h4000_0abc, 3'h0, 0);
        chk(pci_rsp.addr, 32'h8000_0abc);
        pq(32'h4000_1abc, 3'h0, -1);
        rd(12'h004, 32'h0000_0fff, pawd_pkg::RESP_OKAY);
        rd(12'h00c, 32'h0000_0000, pawd_pkg::RESP_SLVERR);
        $display("remap done");
        mq(1'b0, 32'hf100_0000, 14);
        mq(1'b0, 32'h3000_0000, -1);
        rd(12'h300, 32'h3000_0000, pawd_pkg::RESP_OKAY);
        rd(12'h304, 32'h0000_0001, pawd_pkg::RESP_OKAY);
        rd(12'h314, 32'h0000_0003, pawd_pkg::RESP_OKAY);
        chk(cpu_err_int, 1'b0);
        wr(12'h200, 32'h0000_0008);
        mq(1'b1, 32'h0000_0000, -1);
        rd(12'h30c, 32'h0000_0002, pawd_pkg::RESP_OKAY);
        rd(12'h310, 32'h0000_0001, pawd_pkg::RESP_OKAY);
        chk(dma_err_int, 1'b0);
        mq(1'b1, 32'h0080_0000, 1);
        $display("lookup done");
        give_verdict;
    end
endmodule
`default_nettype wire
